// ===== hw/lrb_pkg.sv
// package for the local ram bus master port: widths, lane patterns, carrier structs
package lrb_pkg;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int BE_W   = 4;

    typedef enum logic [1:0] {
        SZ_BYTE,
        SZ_HALF,
        SZ_WORD
    } lrb_size_t;

    // lane enables, bit 3 is bus byte 0 (most significant lane)
    localparam logic [3:0] BE_NONE  = 4'h0;
    localparam logic [3:0] BE_B3    = 4'h1;
    localparam logic [3:0] BE_B2    = 4'h2;
    localparam logic [3:0] BE_B1    = 4'h4;
    localparam logic [3:0] BE_B0    = 4'h8;
    localparam logic [3:0] BE_H23   = 4'h3;
    localparam logic [3:0] BE_H01   = 4'hc;
    localparam logic [3:0] BE_WORD  = 4'hf;

    localparam logic [31:0] ADDR_RST = 32'h0000_0000;
    localparam logic [31:0] DATA_RST = 32'h0000_0000;

    // request from the processor side
    typedef struct packed {
        logic                  valid;
        logic                  write;
        lrb_size_t             size;
        logic [ADDR_W-1:0]     addr;
        logic [DATA_W-1:0]     wdata;
    } lrb_req_t;

    // master outputs on the bus
    typedef struct packed {
        logic [ADDR_W-1:0]     addr;
        logic [BE_W-1:0]       laneEn;
        logic [DATA_W-1:0]     wdata;
        logic                  startStrobe;
        logic                  readStrobe;
        logic                  writeStrobe;
    } lrb_mst_t;

    // slave answers on the bus
    typedef struct packed {
        logic [DATA_W-1:0]     rdata;
        logic                  ready;
        logic                  waitAck;
        logic                  corrErr;
        logic                  uncorrectableErrFlag;
    } lrb_slv_t;

    // completion toward the processor side
    typedef struct packed {
        logic                  done;
        logic                  write;
        logic [DATA_W-1:0]     rdata;
        logic                  corrErr;
        logic                  uncorrectableErrFlag;
    } lrb_rsp_t;
endpackage : lrb_pkg

// ===== hw/lrb_master_port.sv
// local ram bus data-side master port with lane steering
`timescale 1ns/1ps

// Functional notes
// - address valid only with start strobe, in the first cycle of a transfer
// - lane enables qualified by start strobe, limited to the eight legal patterns
// - write data valid with start strobe; only enabled lanes matter
// - start strobe high exactly one cycle per transfer, low otherwise
// - read strobe from first cycle until completion; drops for at least one cycle between back-to-back reads
// - write strobe from first cycle until completion; drops for at least one cycle between back-to-back writes
// - completion sampled at edge; next request taken the following cycle, its start strobe one cycle later
// - correctable error sampled only together with completion
// - uncorrectable error sampled only together with completion
// - everything runs on the single core clock
// - byte, halfword, word steering; never wider than slave, no sizing cycles
// - byte loads: lanes from low address bits, byte into register low byte
// - halfword loads 0011/1100 into low half; word loads bus byte 0 to msb
// - byte stores: register low byte on the lane selected like loads
// - halfword stores low half to bytes 2-3 or 0-1; word stores all four
// - all bus signals active high
module lrb_master_port (
    input  wire logic              sys_clk,
    input  wire logic              rst_b,
    input  wire lrb_pkg::lrb_req_t req,
    output logic                   reqReady,
    output lrb_pkg::lrb_rsp_t      rsp,
    output lrb_pkg::lrb_mst_t      mst,
    input  wire lrb_pkg::lrb_slv_t slv
);
    typedef enum logic {
        ST_IDLE,
        ST_BUSY
    } lrb_state_t;

    typedef struct packed {
        lrb_state_t          state;
        logic                write;
        lrb_pkg::lrb_size_t  size;
        logic [1:0]          lowAddr;
        lrb_pkg::lrb_mst_t   mst;
        lrb_pkg::lrb_rsp_t   rsp;
        logic                reqReady;
    } lrb_regs_t;

    lrb_regs_t st_r;
    lrb_regs_t st_nxt;

    // reset image of every register; the ram behind the bus keeps its own contents
    function automatic lrb_regs_t regsReset();
        lrb_regs_t r;
        r.state = ST_IDLE;
        r.write = 1'b0;
        r.size = lrb_pkg::SZ_WORD;
        r.lowAddr = 2'h0;
        r.mst.addr = lrb_pkg::ADDR_RST;
        r.mst.laneEn = lrb_pkg::BE_NONE;
        r.mst.wdata = lrb_pkg::DATA_RST;
        r.mst.startStrobe = 1'b0;
        r.mst.readStrobe = 1'b0;
        r.mst.writeStrobe = 1'b0;
        r.rsp.done = 1'b0;
        r.rsp.write = 1'b0;
        r.rsp.rdata = lrb_pkg::DATA_RST;
        r.rsp.corrErr = 1'b0;
        r.rsp.uncorrectableErrFlag = 1'b0;
        // ready out of reset so the first request needs no extra cycle
        r.reqReady = 1'b1;
        return r;
    endfunction : regsReset

    // lane enables for a size and the low two address bits; misaligned maps to none
    // a misaligned request still runs a bus cycle, but with no lane enabled nothing changes
    function automatic logic [3:0] laneSel(
        input lrb_pkg::lrb_size_t sz,
        input logic [1:0]         a
    );
        logic [3:0] be;
        be = lrb_pkg::BE_NONE;
        case (sz)
            lrb_pkg::SZ_BYTE: begin
                case (a)
                    2'h3: begin
                        be = lrb_pkg::BE_B3;
                    end
                    2'h2: begin
                        be = lrb_pkg::BE_B2;
                    end
                    2'h1: begin
                        be = lrb_pkg::BE_B1;
                    end
                    default: begin
                        be = lrb_pkg::BE_B0;
                    end
                endcase
            end
            lrb_pkg::SZ_HALF: begin
                case (a)
                    2'h2: begin
                        be = lrb_pkg::BE_H23;
                    end
                    2'h0: begin
                        be = lrb_pkg::BE_H01;
                    end
                    default: begin
                        be = lrb_pkg::BE_NONE;
                    end
                endcase
            end
            default: begin
                // one bus cycle per request: no sizing cycles toward narrow slaves
                case (a)
                    2'h0: begin
                        be = lrb_pkg::BE_WORD;
                    end
                    default: begin
                        be = lrb_pkg::BE_NONE;
                    end
                endcase
            end
        endcase
        return be;
    endfunction : laneSel

    // store steering for one bus lane; lane 0 is bits 7:0 (bus byte 3)
    // narrow data go to every lane they may use, the lane enables pick the real one
    function automatic logic [7:0] storeLane(
        input lrb_pkg::lrb_size_t sz,
        input int unsigned        lane,
        input logic [31:0]        d
    );
        logic [7:0] b;
        case (sz)
            lrb_pkg::SZ_BYTE: begin
                b = d[7:0];
            end
            lrb_pkg::SZ_HALF: begin
                b = (lane % 2 == 0) ? d[7:0] : d[15:8];
            end
            default: begin
                b = d[lane*8+:8];
            end
        endcase
        return b;
    endfunction : storeLane

    // load steering: pick the addressed lanes into the register low end, zero above
    function automatic logic [31:0] loadSteer(
        input lrb_pkg::lrb_size_t sz,
        input logic [1:0]         a,
        input logic [31:0]        d
    );
        logic [31:0] w;
        w = 32'h0000_0000;
        case (sz)
            lrb_pkg::SZ_BYTE: begin
                case (a)
                    2'h3: begin
                        w = {24'h00_0000, d[7:0]};
                    end
                    2'h2: begin
                        w = {24'h00_0000, d[15:8]};
                    end
                    2'h1: begin
                        w = {24'h00_0000, d[23:16]};
                    end
                    default: begin
                        w = {24'h00_0000, d[31:24]};
                    end
                endcase
            end
            lrb_pkg::SZ_HALF: begin
                case (a)
                    2'h2: begin
                        w = {16'h0000, d[15:0]};
                    end
                    2'h0: begin
                        w = {16'h0000, d[31:16]};
                    end
                    default: begin
                        // misaligned: no lane was enabled, so nothing valid came back
                        w = 32'h0000_0000;
                    end
                endcase
            end
            default: begin
                // bus byte 0 lands in the most significant register byte
                w = d;
            end
        endcase
        return w;
    endfunction : loadSteer

    // store data built lane by lane
    logic [31:0] storeBus;
    for (genvar g = 0; g < lrb_pkg::BE_W; g++) begin : g_store_lane
        assign storeBus[g*8+:8] = storeLane(req.size, g, req.wdata);
    end

    logic startNow;
    logic doneNow;

    always_comb begin
        st_nxt = st_r;
        doneNow = (st_r.state == ST_BUSY) && slv.ready;
        // new transfer only when idle or in the cycle after completion is sampled
        startNow = req.valid && st_r.reqReady;
        st_nxt.mst.startStrobe = 1'b0;
        st_nxt.rsp.done = 1'b0;
        st_nxt.reqReady = st_r.reqReady;

        if (doneNow) begin
            st_nxt.rsp.done = 1'b1;
            st_nxt.rsp.write = st_r.write;
            // read data and error flags are taken only on the completion edge
            st_nxt.rsp.rdata = st_r.write ? 32'h0000_0000 : loadSteer(st_r.size, st_r.lowAddr, slv.rdata);
            st_nxt.rsp.corrErr = slv.corrErr;
            st_nxt.rsp.uncorrectableErrFlag = slv.uncorrectableErrFlag;
            st_nxt.state = ST_IDLE;
            st_nxt.reqReady = 1'b1;
            // strobes always drop the cycle after completion; a new transfer can only start from the idle cycle that follows
            st_nxt.mst.readStrobe = 1'b0;
            st_nxt.mst.writeStrobe = 1'b0;
        end

        if (startNow) begin
            st_nxt.state = ST_BUSY;
            st_nxt.reqReady = 1'b0;
            st_nxt.write = req.write;
            st_nxt.size = req.size;
            st_nxt.lowAddr = req.addr[1:0];
            st_nxt.mst.startStrobe = 1'b1;
            st_nxt.mst.addr = req.addr;
            st_nxt.mst.laneEn = laneSel(req.size, req.addr[1:0]);
            st_nxt.mst.wdata = req.write ? storeBus : 32'h0000_0000;
            st_nxt.mst.readStrobe = !req.write;
            st_nxt.mst.writeStrobe = req.write;
        end else if (st_r.state == ST_BUSY && !doneNow) begin
            // hold the strobe and lines through wait states; lines only meaningful in cycle one
            st_nxt.mst.readStrobe = st_r.mst.readStrobe;
            st_nxt.mst.writeStrobe = st_r.mst.writeStrobe;
        end else if (!doneNow && st_r.mst.startStrobe == 1'b0) begin
            // idle: park lanes at none so nothing looks qualified; address keeps its last value
            st_nxt.mst.laneEn = lrb_pkg::BE_NONE;
        end

        // synchronous reset overrides whatever the bus did in this cycle
        if (!rst_b) begin
            st_nxt = regsReset();
        end
    end

    // single clock domain, all outputs registered
    always_ff @(posedge sys_clk) begin
        st_r <= st_nxt;
    end

    assign mst = st_r.mst;
    assign rsp = st_r.rsp;
    assign reqReady = st_r.reqReady;
endmodule : lrb_master_port

// ===== tb/lrb_slave_model.sv
// behavioural block ram slave for the local ram bus, with wait states and error flags
`timescale 1ns/1ps
module lrb_slave_model (
    input  wire logic              sys_clk,
    input  wire logic              rst_b,
    input  wire logic [3:0]        waitCyc,
    input  wire logic [1:0]        errSel,
    input  wire lrb_pkg::lrb_mst_t mst,
    output lrb_pkg::lrb_slv_t      slv
);
    logic [31:0] mem;
    logic [3:0]  cnt;
    logic        busy;
    // word slave attached across all four lanes, so left-justified placement holds trivially
    // ram contents survive reset, like real block ram
    always_ff @(posedge sys_clk) begin
        slv.ready <= 1'b0;
        slv.waitAck <= mst.startStrobe || (busy && cnt != 4'h0);
        slv.corrErr <= 1'b0;
        slv.uncorrectableErrFlag <= 1'b0;
        slv.rdata <= ~slv.rdata; // read bus is garbage outside ready
        if (!rst_b) begin
            busy <= 1'b0;
            slv.rdata <= 32'h0;
        end else if (mst.startStrobe) begin
            busy <= 1'b1;
            cnt <= waitCyc;
            for (int i = 0; i < 4; i++) begin
                if (mst.writeStrobe && mst.laneEn[i]) mem[i*8+:8] <= mst.wdata[i*8+:8];
            end
        end else if (busy && cnt == 4'h0) begin
            busy <= 1'b0;
            slv.ready <= 1'b1;
            slv.rdata <= mem;
            {slv.uncorrectableErrFlag, slv.corrErr} <= errSel;
        end else if (busy) begin
            cnt <= cnt - 4'h1;
        end
    end
endmodule : lrb_slave_model

// ===== tb/lrb_master_port_chk.sv
// concurrent checks on the master port's bus and completion side
`timescale 1ns/1ps
module lrb_master_port_chk (
    input wire logic              sys_clk,
    input wire logic              rst_b,
    input wire lrb_pkg::lrb_req_t req,
    input wire logic              reqReady,
    input wire lrb_pkg::lrb_rsp_t rsp,
    input wire lrb_pkg::lrb_mst_t mst,
    input wire lrb_pkg::lrb_slv_t slv
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    logic act;
    assign act = mst.readStrobe | mst.writeStrobe;
    AST_TAKE: assert property (req.valid && reqReady |=> mst.startStrobe)
        else $error("no start after request taken");
    AST_ONE_START: assert property (mst.startStrobe |=> !mst.startStrobe)
        else $error("start strobe longer than one cycle");
    AST_LANES: assert property (mst.startStrobe |-> mst.laneEn inside {4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc, 4'hf})
        else $error("illegal lane pattern");
    AST_STROBE_RISE: assert property ($rose(mst.readStrobe) || $rose(mst.writeStrobe) |-> mst.startStrobe)
        else $error("strobe rose without start");
    AST_HOLD: assert property (act && !slv.ready |=> act)
        else $error("strobe dropped before completion");
    AST_DONE: assert property (act && slv.ready |=> rsp.done && !act)
        else $error("completion not reported");
    AST_RDATA: assert property (mst.readStrobe && slv.ready && mst.laneEn == 4'hf |=> rsp.rdata == $past(slv.rdata))
        else $error("word read data not captured");
    AST_ERR: assert property (act && slv.ready |=> rsp.corrErr == $past(slv.corrErr)
        && rsp.uncorrectableErrFlag == $past(slv.uncorrectableErrFlag)) else $error("error flags not captured");
    AST_WDATA: assert property (mst.startStrobe && mst.writeStrobe && mst.laneEn == 4'hf |-> mst.wdata == $past(req.wdata))
        else $error("word write data wrong");
endmodule : lrb_master_port_chk

// ===== tb/lrb_master_port_tb.sv
// self-checking bench for the master port: steered transfer table, then reset and misaligned cases
`timescale 1ns/1ps
module lrb_master_port_tb;
    typedef struct packed {
        logic               w;
        lrb_pkg::lrb_size_t sz;
        logic [1:0]         a;
        logic [31:0]        d;
        logic [3:0]         le;
        logic [31:0]        bus;
        logic [1:0]         es;
    } lrb_row_t;
    logic              sys_clk;
    logic              rst_b;
    logic              reqReady;
    logic [3:0]        waitCyc;
    logic [1:0]        errSel;
    lrb_pkg::lrb_req_t req;
    lrb_pkg::lrb_rsp_t rsp;
    lrb_pkg::lrb_mst_t mst;
    lrb_pkg::lrb_slv_t slv;
    int                num_errors;
    int                cmp_count;
    int                cyc;
    lrb_row_t          rows [11];
    lrb_master_port DUT (.sys_clk(sys_clk), .rst_b(rst_b), .req(req), .reqReady(reqReady), .rsp(rsp),
        .mst(mst), .slv(slv));
    lrb_slave_model slave (.sys_clk(sys_clk), .rst_b(rst_b), .waitCyc(waitCyc), .errSel(errSel), .mst(mst),
        .slv(slv));
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic conclude();
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : conclude
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            num_errors++;
            conclude();
        end
    end
    // the next request goes up right after done; the port must hold it off until reqReady
    task automatic xfer(input lrb_row_t r, input logic [3:0] ws);
        int n;
        n = 0;
        waitCyc = ws;
        errSel = r.es;
        req = '{1'b1, r.w, r.sz, {30'h400, r.a}, r.d};
        while (reqReady !== 1'b1 && n++ < 40) @(negedge sys_clk);
        @(negedge sys_clk);
        req.valid = 1'b0;
        chk("start", 32'h1, {31'h0, mst.startStrobe});
        chk("addr", {30'h400, r.a}, mst.addr);
        chk("lanes", {28'h0, r.le}, {28'h0, mst.laneEn});
        chk("strobes", {30'h0, r.w, !r.w}, {30'h0, mst.writeStrobe, mst.readStrobe});
        if (r.w) chk("wbus", r.bus, mst.wdata & {{8{r.le[3]}}, {8{r.le[2]}}, {8{r.le[1]}}, {8{r.le[0]}}});
        while (rsp.done !== 1'b1 && n++ < 40) @(negedge sys_clk);
        chk("rdata", r.w ? 32'h0 : r.d, rsp.rdata);
        chk("rspwr", {31'h0, r.w}, {31'h0, rsp.write});
        chk("errs", {30'h0, r.es}, {30'h0, rsp.uncorrectableErrFlag, rsp.corrErr});
    endtask : xfer
    initial begin
        rst_b = 1'b0;
        req = '0;
        waitCyc = 4'h0;
        errSel = 2'h0;
        rows = '{'{1'b1, lrb_pkg::SZ_WORD, 2'h0, 32'h11223344, 4'hf, 32'h11223344, 2'h0},
            '{1'b0, lrb_pkg::SZ_BYTE, 2'h3, 32'h44, 4'h1, 32'h0, 2'h0},
            '{1'b0, lrb_pkg::SZ_BYTE, 2'h2, 32'h33, 4'h2, 32'h0, 2'h1},
            '{1'b0, lrb_pkg::SZ_BYTE, 2'h1, 32'h22, 4'h4, 32'h0, 2'h0},
            '{1'b0, lrb_pkg::SZ_BYTE, 2'h0, 32'h11, 4'h8, 32'h0, 2'h0},
            '{1'b0, lrb_pkg::SZ_HALF, 2'h2, 32'h3344, 4'h3, 32'h0, 2'h2},
            '{1'b0, lrb_pkg::SZ_HALF, 2'h0, 32'h1122, 4'hc, 32'h0, 2'h0},
            '{1'b0, lrb_pkg::SZ_WORD, 2'h0, 32'h11223344, 4'hf, 32'h0, 2'h0},
            '{1'b1, lrb_pkg::SZ_BYTE, 2'h1, 32'haa, 4'h4, 32'h00aa0000, 2'h2},
            '{1'b1, lrb_pkg::SZ_HALF, 2'h2, 32'hbbcc, 4'h3, 32'h0000bbcc, 2'h1},
            '{1'b0, lrb_pkg::SZ_WORD, 2'h0, 32'h11aabbcc, 4'hf, 32'h0, 2'h3}};
        repeat (12) @(negedge sys_clk);
        rst_b = 1'b1;
        foreach (rows[i]) xfer(rows[i], 4'(i % 3));
        rst_b = 1'b0;
        repeat (2) @(negedge sys_clk);
        chk("rstbus", 32'h0, {31'h0, |mst});
        chk("rstrdy", 32'h1, {31'h0, reqReady});
        rst_b = 1'b1;
        xfer('{1'b1, lrb_pkg::SZ_HALF, 2'h1, 32'h5555, 4'h0, 32'h0, 2'h0}, 4'h2);
        xfer(rows[10], 4'h5);
        conclude();
    end
endmodule : lrb_master_port_tb
bind lrb_master_port lrb_master_port_chk chk_i (.sys_clk(sys_clk), .rst_b(rst_b), .req(req),
    .reqReady(reqReady), .rsp(rsp), .mst(mst), .slv(slv));
